// >>> rtl/sst_pkg.sv
// Shared constants and types of the synchronous slave serial transmitter.
// Assumes one system clock domain for the register side; the shift clock is sampled.
package sst_pkg;

    // ************************************************************
    // Register map, one byte per index on the plain register port.
    // ************************************************************
    localparam logic [3:0] ADR_RXSC  = 4'h0;  // receive_status_control
    localparam logic [3:0] ADR_THR   = 4'h1;  // transmit_holding, write only
    localparam logic [3:0] ADR_TXSC  = 4'h2;  // transmit_status_control
    localparam logic [3:0] ADR_BAUD  = 4'h3;  // baud_control
    localparam logic [3:0] ADR_DIVH  = 4'h4;  // baud_divisor_high
    localparam logic [3:0] ADR_DIVL  = 4'h5;  // baud_divisor_low
    localparam logic [3:0] ADR_ISTAT = 4'h6;  // interrupt status, read only
    localparam logic [3:0] ADR_ICLR  = 4'h7;  // interrupt clear, write only
    localparam logic [3:0] ADR_IEN   = 4'h8;  // interrupt enable
    localparam logic [3:0] ADR_ICTL  = 4'h9;  // irq_control_reg

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int RXSC_PORT_EN_BIT = 7;      // serial_port_enable
    localparam int RXSC_SINGLE_BIT  = 5;      // single_rx_enable
    localparam int RXSC_CONT_BIT    = 4;      // continuous_rx_enable
    localparam int TXSC_CLKSEL_BIT  = 7;      // clock_source_select
    localparam int TXSC_NINE_BIT    = 6;      // nine_bit_tx_select
    localparam int TXSC_TRANSMITTER_ENABLE_BIT    = 5;      // transmitter_enable
    localparam int TXSC_SYNC_BIT    = 4;      // synchronous mode
    localparam int TXSC_EMPTY_BIT   = 1;      // shift_reg_empty, read only
    localparam int TXSC_NINTH_BIT   = 0;      // ninth_tx_bit
    localparam int BAUD_POL_BIT     = 4;      // clock idle level select
    localparam int IRQ_TX_BIT       = 0;      // transmit event
    localparam int ICTL_GLOBAL_BIT  = 7;      // global_irq_enable
    localparam int ICTL_PERIPH_BIT  = 6;      // peripheral_irq_enable

    // ************************************************************
    // Masks, reset values and fixed levels.
    // ************************************************************
    localparam logic [7:0] RXSC_MASK = 8'hb0;
    localparam logic [7:0] TXSC_MASK = 8'hf1;
    localparam logic [7:0] BAUD_MASK = 8'hfb;  // Bit 2 is unimplemented.
    localparam logic [7:0] REG_RST   = 8'h00;
    localparam logic [3:0] LEN_8     = 4'h8;
    localparam logic [3:0] LEN_9     = 4'h9;
    localparam logic       IDLE_LVL  = 1'b1;

    // ************************************************************
    // Types.
    // ************************************************************
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sst_bus_s;

    typedef enum logic [1:0] {
        SH_IDLE  = 2'b00,
        SH_SHIFT = 2'b01
    } sst_shift_e;

endpackage

// >>> rtl/sst_sync2.sv
// Two-stage synchroniser for one level arriving from outside the clock domain.
// Assumes the input may change at any time relative to clk.
module sst_sync2
    import sst_pkg::*;
(
    input  wire logic clk,    // System clock.
    input  wire logic rstn,   // Asynchronous reset, active low.
    input  wire logic d,      // Asynchronous level.
    output logic      q       // Synchronised level.
);

    logic meta_ff;
    logic nxt_meta;
    logic nxt_q;

    // The first stage feeds only the second stage.
    always_comb begin
        nxt_meta = d;
        nxt_q    = meta_ff;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= 1'b0;
            q       <= 1'b0;
        end else begin
            meta_ff <= nxt_meta;
            q       <= nxt_q;
        end
    end

endmodule // sst_sync2

// >>> rtl/sst_shifter.sv
// Shift register that sends one word, least significant bit first.
// Assumes adv is a one-cycle pulse per shift clock cycle.
module sst_shifter
    import sst_pkg::*;
(
    input  wire logic       clk,    // System clock.
    input  wire logic       rstn,   // Asynchronous reset, active low.
    input  wire logic       flush,  // Drops the word in flight.
    input  wire logic       load,   // Takes a new word when idle.
    input  wire logic [8:0] data,   // Word to send.
    input  wire logic [3:0] len,    // Bits in the word.
    input  wire logic       adv,    // Move to the next bit.
    output logic            busy,   // A word is in the shift register.
    output logic            done,   // Last bit left, one cycle.
    output logic            bit_o   // Bit now on the line.
);

    sst_shift_e state_ff;
    sst_shift_e nxt_state;
    logic [8:0] sreg_ff;
    logic [8:0] nxt_sreg;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;

    // Count the bits down; the word ends on the advance after its last bit.
    always_comb begin
        nxt_state = state_ff;
        nxt_sreg  = sreg_ff;
        nxt_cnt   = cnt_ff;
        done      = 1'b0;
        case (state_ff)
            SH_IDLE: begin
                if (load && !flush) begin
                    nxt_sreg  = data;
                    nxt_cnt   = len;
                    nxt_state = SH_SHIFT;
                end
            end
            SH_SHIFT: begin
                if (flush) begin
                    nxt_state = SH_IDLE;
                end else if (adv) begin
                    nxt_sreg = {1'b0, sreg_ff[8:1]};
                    nxt_cnt  = cnt_ff - 4'h1;
                    if (cnt_ff == 4'h1) begin
                        nxt_state = SH_IDLE;
                        done      = 1'b1;
                    end
                end
            end
            default: nxt_state = SH_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= SH_IDLE;
            sreg_ff  <= 9'h000;
            cnt_ff   <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            sreg_ff  <= nxt_sreg;
            cnt_ff   <= nxt_cnt;
        end
    end

    assign busy  = (state_ff == SH_SHIFT);
    assign bit_o = sreg_ff[0];

endmodule // sst_shifter

// >>> rtl/sst_top.sv
// Transmit path of a synchronous serial port with registers, interrupt and wake logic.
// Assumes a register master on CLK and a shift clock pin that is asynchronous to CLK.
//
// The strobed register port and the register addresses were chosen for this implementation.
module sst_top
    import sst_pkg::*;
(
    input  wire logic       CLK,      // System clock, 100 MHz.
    input  wire logic       RSTN,     // Asynchronous reset, active low.
    input  wire logic [3:0] ADDR,     // Register index.
    input  wire logic [7:0] WDATA,    // Write data.
    input  wire logic       WR,       // Write strobe.
    input  wire logic       RD,       // Read strobe.
    output logic      [7:0] RDATA,    // Read data, cycle after RD.
    input  wire logic       SLEEP,    // Chip is in Sleep.
    input  wire logic       CK_I,     // Shift clock pin level.
    output logic            CK_O,     // Shift clock driven in master mode.
    output logic            CK_OE,    // Shift clock drive enable.
    output logic            DT_O,     // Data line level.
    output logic            DT_OE,    // Data line drive enable.
    output logic            IRQ,      // Enabled status bit set.
    output logic            WAKE,     // Wake request from Sleep.
    output logic            VECTOR    // Branch to interrupt vector.
);

    // ************************************************************
    // Register port and control registers.
    // ************************************************************
    sst_bus_s   bus;
    logic [7:0] rxsc_ff, nxt_rxsc, txsc_ff, nxt_txsc, baud_ff, nxt_baud;
    logic [7:0] divh_ff, nxt_divh, divl_ff, nxt_divl, ien_ff, nxt_ien;
    logic [7:0] ictl_ff, nxt_ictl, stat_ff, nxt_stat, nxt_rdata;
    logic [7:0] hold_ff, nxt_hold;
    logic       hold_full_ff, nxt_hold_full;
    logic       tx_on, slave, pol, empty, tx_irq_flag, xfer, thr_wr;
    logic       sh_busy, sh_done, sh_bit, adv;
    logic [3:0] ld_len;

    assign bus         = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
    assign tx_on       = rxsc_ff[RXSC_PORT_EN_BIT] & txsc_ff[TXSC_SYNC_BIT] & txsc_ff[TXSC_TRANSMITTER_ENABLE_BIT];
    assign slave       = ~txsc_ff[TXSC_CLKSEL_BIT];
    assign pol         = baud_ff[BAUD_POL_BIT];
    assign thr_wr      = bus.wr && (bus.addr == ADR_THR);
    assign xfer        = hold_full_ff && !sh_busy && tx_on;
    assign tx_irq_flag = ~hold_full_ff;
    assign empty       = ~sh_busy & ~hold_full_ff;
    assign ld_len      = txsc_ff[TXSC_NINE_BIT] ? LEN_9 : LEN_8;

    // Writes; a write to a full holding register is dropped without any flag, so the held word is never overwritten.
    always_comb begin
        nxt_rxsc      = rxsc_ff;
        nxt_txsc      = txsc_ff;
        nxt_baud      = baud_ff;
        nxt_divh      = divh_ff;
        nxt_divl      = divl_ff;
        nxt_ien       = ien_ff;
        nxt_ictl      = ictl_ff;
        nxt_hold      = hold_ff;
        nxt_hold_full = hold_full_ff;
        nxt_stat      = stat_ff;
        if (xfer) begin
            nxt_hold_full = 1'b0;
        end
        if (bus.wr) begin
            if (bus.addr == ADR_RXSC) begin
                nxt_rxsc = bus.wdata & RXSC_MASK;
            end else if (bus.addr == ADR_THR) begin
                if (!hold_full_ff) begin
                    nxt_hold      = bus.wdata;
                    nxt_hold_full = 1'b1;
                end
            end else if (bus.addr == ADR_TXSC) begin
                nxt_txsc = bus.wdata & TXSC_MASK;
            end else if (bus.addr == ADR_BAUD) begin
                nxt_baud = bus.wdata & BAUD_MASK;
            end else if (bus.addr == ADR_DIVH) begin
                nxt_divh = bus.wdata;
            end else if (bus.addr == ADR_DIVL) begin
                nxt_divl = bus.wdata;
            end else if (bus.addr == ADR_ICLR) begin
                nxt_stat = stat_ff & ~bus.wdata;
            end else if (bus.addr == ADR_IEN) begin
                nxt_ien = bus.wdata;
            end else if (bus.addr == ADR_ICTL) begin
                nxt_ictl = bus.wdata;
            end
        end
        // The event sets after any clear, so a set in the clear cycle survives.
        if (xfer) begin
            nxt_stat[IRQ_TX_BIT] = 1'b1;
        end
    end

    // Read data; write-only and unmapped indices read as zero.
    always_comb begin
        nxt_rdata = 8'h00;
        if (bus.rd) begin
            if (bus.addr == ADR_RXSC) begin
                nxt_rdata = rxsc_ff;
            end else if (bus.addr == ADR_TXSC) begin
                nxt_rdata = txsc_ff;
                nxt_rdata[TXSC_EMPTY_BIT] = empty;
            end else if (bus.addr == ADR_BAUD) begin
                nxt_rdata = baud_ff & BAUD_MASK;
            end else if (bus.addr == ADR_DIVH) begin
                nxt_rdata = divh_ff;
            end else if (bus.addr == ADR_DIVL) begin
                nxt_rdata = divl_ff;
            end else if (bus.addr == ADR_ISTAT) begin
                nxt_rdata = stat_ff;
            end else if (bus.addr == ADR_IEN) begin
                nxt_rdata = ien_ff;
            end else if (bus.addr == ADR_ICTL) begin
                nxt_rdata = ictl_ff;
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rxsc_ff      <= REG_RST;
            txsc_ff      <= REG_RST;
            baud_ff      <= REG_RST;
            divh_ff      <= REG_RST;
            divl_ff      <= REG_RST;
            ien_ff       <= REG_RST;
            ictl_ff      <= REG_RST;
            stat_ff      <= REG_RST;
            hold_ff      <= REG_RST;
            hold_full_ff <= 1'b0;
            RDATA        <= REG_RST;
        end else begin
            rxsc_ff      <= nxt_rxsc;
            txsc_ff      <= nxt_txsc;
            baud_ff      <= nxt_baud;
            divh_ff      <= nxt_divh;
            divl_ff      <= nxt_divl;
            ien_ff       <= nxt_ien;
            ictl_ff      <= nxt_ictl;
            stat_ff      <= nxt_stat;
            hold_ff      <= nxt_hold;
            hold_full_ff <= nxt_hold_full;
            RDATA        <= nxt_rdata;
        end
    end

    // ************************************************************
    // Shift clock: sampled pin in slave mode, divider in master mode.
    // ************************************************************
    logic        ck_sync, ck_last_ff, nxt_ck_last, mclk_ff, nxt_mclk;
    logic [15:0] div_cnt_ff, nxt_div_cnt;
    logic        m_toggle;

    sst_sync2 u_ck_sync (
        .clk  (CLK),
        .rstn (RSTN),
        .d    (CK_I),
        .q    (ck_sync)
    );

    // Master clocking halts in Sleep; slave clocking comes from the far party.
    assign m_toggle = !slave && sh_busy && !SLEEP && (div_cnt_ff == {divh_ff, divl_ff});

    always_comb begin
        nxt_ck_last = ck_sync ^ pol;
        nxt_div_cnt = div_cnt_ff;
        nxt_mclk    = mclk_ff;
        if (slave || !sh_busy) begin
            nxt_div_cnt = 16'h0000;
            nxt_mclk    = 1'b0;
        end else if (!SLEEP) begin
            nxt_div_cnt = m_toggle ? 16'h0000 : div_cnt_ff + 16'h0001;
            nxt_mclk    = mclk_ff ^ m_toggle;
        end
        // The data moves on the trailing edge so the master samples on the leading one.
        if (slave) begin
            adv = ck_last_ff && !nxt_ck_last;
        end else begin
            adv = mclk_ff && m_toggle;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ck_last_ff <= 1'b0;
            div_cnt_ff <= 16'h0000;
            mclk_ff    <= 1'b0;
        end else begin
            ck_last_ff <= nxt_ck_last;
            div_cnt_ff <= nxt_div_cnt;
            mclk_ff    <= nxt_mclk;
        end
    end

    // ************************************************************
    // Shift register and pin outputs.
    // ************************************************************
    sst_shifter u_shift (
        .clk   (CLK),
        .rstn  (RSTN),
        .flush (!tx_on),
        .load  (xfer),
        .data  ({txsc_ff[TXSC_NINTH_BIT], hold_ff}),
        .len   (ld_len),
        .adv   (adv),
        .busy  (sh_busy),
        .done  (sh_done),
        .bit_o (sh_bit)
    );

    // All pin and interrupt outputs are registered so they never glitch.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            DT_O   <= IDLE_LVL;
            DT_OE  <= 1'b0;
            CK_O   <= 1'b0;
            CK_OE  <= 1'b0;
            IRQ    <= 1'b0;
            WAKE   <= 1'b0;
            VECTOR <= 1'b0;
        end else begin
            DT_O   <= sh_busy ? sh_bit : IDLE_LVL;
            DT_OE  <= tx_on;
            CK_O   <= nxt_mclk ^ pol;
            CK_OE  <= tx_on && !slave;
            IRQ    <= |(nxt_stat & nxt_ien);
            WAKE   <= SLEEP && tx_irq_flag && ien_ff[IRQ_TX_BIT];
            VECTOR <= IRQ && ictl_ff[ICTL_GLOBAL_BIT] && ictl_ff[ICTL_PERIPH_BIT];
        end
    end

    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    property p_xfer_start;
        hold_full_ff && !sh_busy && tx_on |=> sh_busy && !hold_full_ff;
    endproperty
    a_xfer_start: assert property (p_xfer_start) else $error("Held word did not start.");

    property p_second_held;
        sh_busy && hold_full_ff && tx_on && !sh_done |=> hold_full_ff;
    endproperty
    a_second_held: assert property (p_second_held) else $error("Second word left early.");

    property p_flag_clear;
        hold_full_ff && $past(hold_full_ff) |-> !WAKE && !$rose(stat_ff[IRQ_TX_BIT]);
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("Flag set while word held.");

    property p_second_moves;
        sh_done && hold_full_ff && tx_on |=> ##1 sh_busy && tx_irq_flag && stat_ff[IRQ_TX_BIT];
    endproperty
    a_second_moves: assert property (p_second_moves) else $error("Second word not moved.");

    property p_wake;
        SLEEP && tx_irq_flag && ien_ff[IRQ_TX_BIT] |=> WAKE;
    endproperty
    a_wake: assert property (p_wake) else $error("No wake on transmit flag.");

    property p_vector;
        IRQ && ictl_ff[ICTL_GLOBAL_BIT] && ictl_ff[ICTL_PERIPH_BIT] |=> VECTOR;
    endproperty
    a_vector: assert property (p_vector) else $error("No vector request.");

    property p_nine;
        xfer && txsc_ff[TXSC_NINE_BIT] |=> sh_busy ##0 (u_shift.cnt_ff == LEN_9);
    endproperty
    a_nine: assert property (p_nine) else $error("Nine-bit word not loaded as nine.");

    property p_start_on_write;
        thr_wr && !hold_full_ff && !sh_busy && tx_on |=> ##1 sh_busy;
    endproperty
    a_start_on_write: assert property (p_start_on_write) else $error("Write did not start.");

    property p_bit2_zero;
        bus.rd && bus.addr == ADR_BAUD |=> RDATA[2] == 1'b0;
    endproperty
    a_bit2_zero: assert property (p_bit2_zero) else $error("Baud bit 2 not zero.");

    property p_sleep_shift;
        slave && sh_busy && tx_on && SLEEP && ck_last_ff && !(ck_sync ^ pol) |=> u_shift.cnt_ff != $past(u_shift.cnt_ff);
    endproperty
    a_sleep_shift: assert property (p_sleep_shift) else $error("Slave stalled in Sleep.");

    property p_idle_line;
        !sh_busy |=> DT_O == IDLE_LVL;
    endproperty
    a_idle_line: assert property (p_idle_line) else $error("Line not idle.");

    property p_empty;
        bus.rd && bus.addr == ADR_TXSC && (sh_busy || hold_full_ff) |=> !RDATA[TXSC_EMPTY_BIT];
    endproperty
    a_empty: assert property (p_empty) else $error("Empty reported early.");

    c_two_words: cover property (sh_busy && hold_full_ff && SLEEP);
    c_wake: cover property ($rose(WAKE));
    c_nine: cover property (sh_done && txsc_ff[TXSC_NINE_BIT]);

endmodule // sst_top

// >>> tb/sst_master_model.sv
// Behavioural synchronous master that clocks words out of the slave transmitter.
// Assumes clock idle level low and that frame is called only with a word loaded.
module sst_master_model (
    output logic      ck,  // Shift clock to the slave.
    input  wire logic dt   // Data line from the slave.
);
    timeunit 1ns;
    timeprecision 1ps;
    // The clock stands low between frames; it never runs free.
    initial begin
        ck = 1'b0;
    end
    // One 80 ns period per bit, LSB first. A bit is taken just before the
    // trailing edge, since the slave only moves after it sees that edge.
    task automatic frame(input int n, output logic [8:0] w);
        w = '0;
        for (int i = 0; i < n; i++) begin
            #40 ck = 1'b1;
            #40 w[i] = dt;
            ck = 1'b0;
        end
    endtask
endmodule // sst_master_model

// >>> tb/sst_top_test.sv
// Self-checking bench of the slave transmitter: registers, words, Sleep and interrupt.
// Assumes the master model on the shift clock pin and a 100 MHz system clock.
module sst_top_test;
    import sst_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic       CLK, RSTN, WR, RD, SLEEP, CK, DT_O, IRQ, WAKE, VECTOR, CK_O, CK_OE, DT_OE;
    logic [3:0] ADDR;
    logic [7:0] WDATA, RDATA, v, d;
    logic [8:0] got;
    logic       nine, b9;
    logic [7:0] b [2];
    int         err_count, n_compared;
    sst_top dut (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .SLEEP(SLEEP), .CK_I(CK), .CK_O(CK_O), .CK_OE(CK_OE), .DT_O(DT_O),
        .DT_OE(DT_OE), .IRQ(IRQ), .WAKE(WAKE), .VECTOR(VECTOR));
    sst_master_model mst (.ck(CK), .dt(DT_O));
    // **********************************
    // Clock, watchdog and shared tasks.
    // **********************************
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    // A hang counts as a mismatch, so a stuck run can never pass.
    initial begin
        #200000 err_count++;
        final_report;
    end
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // Waits past the edge so registered outputs are settled when looked at.
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    // Master mode: takes one bit on each leading edge of the driven clock, bounded.
    task automatic mframe(output logic [8:0] w);
        logic last;
        int   k;
        w = '0;
        last = 1'b0;
        k = 0;
        for (int t = 0; t < 400 && k < 8; t++) begin
            @(posedge CLK);
            #1;
            if (CK_O && !last) begin
                w[k] = DT_O;
                k++;
            end
            last = CK_O;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] dd);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= dd;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, output logic [7:0] dd);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1 dd = RDATA;
    endtask
    function automatic logic [8:0] expw(input logic n9, input logic t9, input logic [7:0] dd);
        return {n9 & t9, dd};
    endfunction
    // Polls the empty bit with a bounded number of reads.
    task automatic wait_empty;
        for (int i = 0; i < 20; i++) begin
            rd(ADR_TXSC, v);
            if (v[TXSC_EMPTY_BIT] === 1'b1) return;
        end
        err_count++;
        $display("unexpected at %0t: shift register never empty", $time);
        final_report;
    endtask
    // **********************************
    // Main sequence.
    // **********************************
    initial begin
        RSTN = 1'b0;
        WR = 1'b0;
        RD = 1'b0;
        SLEEP = 1'b0;
        ADDR = '0;
        WDATA = '0;
        err_count = 0;
        n_compared = 0;
        void'($urandom(34385));
        repeat (3) @(posedge CLK);
        RSTN <= 1'b1;
        wr(ADR_BAUD, 8'hff);
        rd(ADR_BAUD, v);
        chk(v, BAUD_MASK);
        rd(4'ha, v);
        chk(v, 8'h00);
        chk(DT_O, IDLE_LVL);
        chk(DT_OE, 1'b0);
        wr(ADR_BAUD, 8'h00);
        wr(ADR_RXSC, 8'h80);
        wr(ADR_IEN, 8'h01);
        wr(ADR_ICTL, 8'hc0);
        $display("test registers done");
        // Mixed 8- and 9-bit words; the first is a lone set bit as a corner case.
        for (int i = 0; i < 6; i++) begin
            nine = i[0];
            b9 = 1'($urandom);
            d = (i == 0) ? 8'h01 : 8'($urandom);
            wr(ADR_TXSC, {1'b0, nine, 2'b11, 3'b000, b9});
            wr(ADR_THR, d);
            cyc(4);
            mst.frame(nine ? 9 : 8, got);
            chk(got, expw(nine, b9, d));
            wait_empty;
        end
        $display("test words done");
        wr(ADR_TXSC, 8'h30);
        b[0] = 8'($urandom);
        b[1] = 8'($urandom);
        wr(ADR_THR, b[0]);
        cyc(4);
        wr(ADR_THR, b[1]);
        SLEEP <= 1'b1;
        wr(ADR_ICLR, 8'h01);
        cyc(3);
        chk(WAKE, 1'b0);
        chk(IRQ, 1'b0);
        rd(ADR_TXSC, v);
        chk(v[TXSC_EMPTY_BIT], 1'b0);
        mst.frame(8, got);
        chk(got, b[0]);
        cyc(10);
        chk(IRQ, 1'b1);
        chk(WAKE, 1'b1);
        chk(VECTOR, 1'b1);
        mst.frame(8, got);
        chk(got, b[1]);
        chk(CK_OE, 1'b0);
        chk(DT_OE, 1'b1);
        @(posedge CLK);
        SLEEP <= 1'b0;
        wait_empty;
        $display("test sleep done");
        wr(ADR_IEN, 8'h00);
        cyc(2);
        chk(IRQ, 1'b0);
        rd(ADR_ISTAT, v);
        chk(v[IRQ_TX_BIT], 1'b1);
        wr(ADR_IEN, 8'h01);
        cyc(2);
        chk(IRQ, 1'b1);
        wr(ADR_ICLR, 8'h01);
        cyc(2);
        chk(IRQ, 1'b0);
        $display("test interrupt done");
        // Master clocking must send the same order as slave clocking.
        wr(ADR_DIVL, 8'h03);
        wr(ADR_TXSC, 8'hb0);
        d = 8'($urandom);
        wr(ADR_THR, d);
        mframe(got);
        chk(got, {1'b0, d});
        chk(CK_OE, 1'b1);
        wait_empty;
        $display("test master done");
        final_report;
    end
endmodule // sst_top_test
